// ===== ccu_pkg.sv
// constants, field layouts and carrier types of the capture/compare channel
// assumes one 200 MHz clock shared by the channel and its timers
package ccu_pkg;
  localparam int DATA_W = 16;
  localparam int MODE_W = 4;
  localparam int PRESC_W = 4;

  // channel mode field encodings
  localparam logic [MODE_W-1:0] MODE_OFF = 4'h0;
  localparam logic [MODE_W-1:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [MODE_W-1:0] MODE_CAP_FALL = 4'h4;
  localparam logic [MODE_W-1:0] MODE_CAP_RISE = 4'h5;
  localparam logic [MODE_W-1:0] MODE_CAP_DIV4 = 4'h6;
  localparam logic [MODE_W-1:0] MODE_CAP_DIV16 = 4'h7;
  localparam logic [MODE_W-1:0] MODE_CMP_HIGH = 4'h8;
  localparam logic [MODE_W-1:0] MODE_CMP_LOW = 4'h9;
  localparam logic [MODE_W-1:0] MODE_CMP_SWINT = 4'ha;
  localparam logic [MODE_W-1:0] MODE_CMP_SEVT = 4'hb;

  // capture modes share the upper two mode bits
  localparam logic [1:0] CAP_GROUP = 2'h1;

  // prescaler counter terminal and reset values
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [PRESC_W-1:0] DIV16_LAST = 4'hf;
  localparam logic [PRESC_W-1:0] PRESC_RST = 4'h0;

  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic PIN_MAP_PORT_E = 1'b1;

  // prescaler select, taken from the low mode bits
  typedef enum logic [1:0] {
    PS_FALL = 2'h0,
    PS_RISE = 2'h1,
    PS_DIV4 = 2'h2,
    PS_DIV16 = 2'h3
  } ccu_presc_t;

  // one-hot mode family
  typedef enum logic [2:0] {
    FAM_OFF = 3'b001,
    FAM_CAPTURE = 3'b010,
    FAM_COMPARE = 3'b100
  } ccu_family_t;

  typedef struct packed {
    logic e_level;
    logic h_level;
  } ccu_pad_in_t;

  typedef struct packed {
    logic e_drive;
    logic e_oe_n;
    logic h_drive;
    logic h_oe_n;
  } ccu_pads_t;

  function automatic ccu_family_t mode_family(input logic [MODE_W-1:0] mode);
    if (mode[3:2] == CAP_GROUP)
      return FAM_CAPTURE;
    else if (mode == MODE_CMP_TOGGLE || mode[3:2] == 2'h2)
      return FAM_COMPARE;
    else
      return FAM_OFF;
  endfunction
endpackage

// ===== ccu_pin_sync.sv
// two-flop synchroniser for the channel's pad inputs
// assumes pads are asynchronous to the system clock
`timescale 1ns/1ps
module ccu_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;

  // first stage feeds only the second
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      meta <= '0;
      stable <= '0;
    end
    else
    begin
      meta <= async_in;
      stable <= meta;
    end
  end

  assign sync_out = stable;
endmodule

// ===== ccu_prescaler.sv
// edge detector and capture prescaler
// assumes level_in is already in the clock domain
`timescale 1ns/1ps
module ccu_prescaler (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic enable_in,
  input wire logic level_in,
  input wire ccu_pkg::ccu_presc_t sel_in,
  output logic strobe_out
);
  import ccu_pkg::*;

  logic level_q;
  logic [PRESC_W-1:0] cnt;
  logic strobe;
  logic next_level_q;
  logic [PRESC_W-1:0] next_cnt;
  logic next_strobe;
  logic rise;
  logic fall;

  assign rise = level_in && !level_q;
  assign fall = !level_in && level_q;

  // counter runs on rising edges; a select change keeps the count
  always_comb
  begin
    next_level_q = level_in;
    next_cnt = cnt;
    next_strobe = 1'b0;
    if (!enable_in)
      next_cnt = PRESC_RST;
    else
    begin
      if (rise)
        next_cnt = cnt + 4'h1;
      case (sel_in)
        PS_FALL: next_strobe = fall;
        PS_RISE: next_strobe = rise;
        PS_DIV4: next_strobe = rise && (cnt[1:0] == DIV4_LAST);
        PS_DIV16: next_strobe = rise && (cnt == DIV16_LAST);
        default: next_strobe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      level_q <= 1'b0;
      cnt <= PRESC_RST;
      strobe <= 1'b0;
    end
    else
    begin
      level_q <= next_level_q;
      cnt <= next_cnt;
      strobe <= next_strobe;
    end
  end

  assign strobe_out = strobe;

  chk_presc_clear: assert property (@(posedge clk_in) disable iff (srst_in)
    !enable_in |=> cnt == PRESC_RST)
    else $error("prescaler count not cleared while disabled");

  chk_presc_keep: assert property (@(posedge clk_in) disable iff (srst_in)
    (enable_in && !rise) |=> cnt == $past(cnt))
    else $error("prescaler count changed without an edge");

  chk_div16_edge: assert property (@(posedge clk_in) disable iff (srst_in)
    (strobe_out && $past(sel_in) == PS_DIV16) |-> $past(cnt) == DIV16_LAST)
    else $error("divide-by-16 strobe at wrong count");
endmodule

// ===== ccu_channel.sv
// capture/compare channel: capture of a timer on pin edges, compare and pin action
// assumes timers and control inputs share REF_CLK_IN; pads are asynchronous
// Behaviour
// - pin-map bit 1 (default) uses port E pin, 0 uses port H pin
// - capture copies the full 16-bit selected timer into the data register
// - mode selects falling, rising, every 4th or every 16th rising edge
// - each capture sets the irq flag; only software clears it
// - a new capture overwrites the old value unconditionally
// - with pin as output in capture mode, port writes cause captures
// - prescaler clears when channel is off or not capturing
// - switching prescaler settings keeps the count, may raise interrupt
// - compare mode matches data register against selected timer continuously
// - match drives high, low, toggles or leaves pin; sets flag
// - mode zero forces compare latch low; port latch untouched
// - software-interrupt mode leaves pin, only raises the interrupt
// - mode 1011 pulses a special event trigger on match
// - special event resets the currently selected timer
// - special event never starts an analogue conversion
// - timers are only read, except for the special event reset, so several channels may share one
`timescale 1ns/1ps
module ccu_channel #(
  parameter bit PIN_MAPPABLE = 1'b1
) (
  input wire logic REF_CLK_IN,
  input wire logic SRST_IN,
  input wire logic PIN_MAP_SELECT_IN,
  input wire ccu_pkg::ccu_pad_in_t PAD_IN,
  input wire logic PIN_DIR_IN,
  input wire logic PORT_LATCH_IN,
  input wire logic [ccu_pkg::MODE_W-1:0] CHANNEL_MODE_IN,
  input wire logic DATA_WR_IN,
  input wire logic [ccu_pkg::DATA_W-1:0] DATA_WDATA_IN,
  input wire logic IRQ_FLAG_CLR_IN,
  input wire logic IRQ_ENABLE_IN,
  input wire logic TIMER_SEL_IN,
  input wire logic [ccu_pkg::DATA_W-1:0] TIMER_A_IN,
  input wire logic [ccu_pkg::DATA_W-1:0] TIMER_B_IN,
  output logic [ccu_pkg::DATA_W-1:0] DATA_OUT,
  output logic IRQ_FLAG_OUT,
  output logic IRQ_OUT,
  output logic SPECIAL_EVENT_OUT,
  output logic TIMER_A_RESET_OUT,
  output logic TIMER_B_RESET_OUT,
  output ccu_pkg::ccu_pads_t PAD_OUT
);
  import ccu_pkg::*;

  logic pin_map;
  logic next_pin_map;
  logic [1:0] pad_sync;
  logic cap_level;
  logic cap_strobe;
  ccu_family_t family;
  logic [DATA_W-1:0] tval;
  logic match;
  logic match_q;
  logic next_match_q;
  logic cmp_event;
  logic [DATA_W-1:0] data;
  logic [DATA_W-1:0] next_data;
  logic flag;
  logic next_flag;
  logic irq;
  logic next_irq;
  logic cmp_latch;
  logic next_cmp_latch;
  logic sevt;
  logic next_sevt;
  logic rst_a;
  logic next_rst_a;
  logic rst_b;
  logic next_rst_b;
  ccu_pads_t pads;
  ccu_pads_t next_pads;
  logic use_port_e;

  // strap caught on every clock while reset is held, kept afterwards
  always_comb
  begin
    next_pin_map = SRST_IN ? PIN_MAP_SELECT_IN : pin_map;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    pin_map <= next_pin_map;
  end

  // unmappable channels always sit on the port E pin
  assign use_port_e = !PIN_MAPPABLE || (pin_map == PIN_MAP_PORT_E);

  // pads are asynchronous, so both pass two flops first
  ccu_pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(REF_CLK_IN),
    .srst_in(SRST_IN),
    .async_in({PAD_IN.e_level, PAD_IN.h_level}),
    .sync_out(pad_sync)
  );

  // an output pin reflects the port latch, so a port write looks like an edge
  always_comb
  begin
    if (!PIN_DIR_IN)
      cap_level = PORT_LATCH_IN;
    else if (use_port_e)
      cap_level = pad_sync[1];
    else
      cap_level = pad_sync[0];
  end

  assign family = mode_family(CHANNEL_MODE_IN);

  // prescaler held clear outside capture mode
  ccu_prescaler u_presc (
    .clk_in(REF_CLK_IN),
    .srst_in(SRST_IN),
    .enable_in(family == FAM_CAPTURE),
    .level_in(cap_level),
    .sel_in(ccu_presc_t'(CHANNEL_MODE_IN[1:0])),
    .strobe_out(cap_strobe)
  );

  // timers are only read here, never owned
  assign tval = TIMER_SEL_IN ? TIMER_B_IN : TIMER_A_IN;

  // act once per match, not every cycle the timer rests on the value
  assign match = (family == FAM_COMPARE) && (tval == data);
  assign cmp_event = match && !match_q;

  // capture wins over a software write in the same cycle
  always_comb
  begin
    next_data = data;
    next_match_q = match;
    if (cap_strobe && family == FAM_CAPTURE)
      next_data = tval;
    else if (DATA_WR_IN)
      next_data = DATA_WDATA_IN;
  end

  // flag: hardware set beats the software clear
  always_comb
  begin
    next_flag = flag;
    if (IRQ_FLAG_CLR_IN)
      next_flag = 1'b0;
    if ((cap_strobe && family == FAM_CAPTURE) || cmp_event)
      next_flag = 1'b1;
    next_irq = next_flag && IRQ_ENABLE_IN;
  end

  // compare output latch and trigger pulses
  always_comb
  begin
    next_cmp_latch = cmp_latch;
    next_sevt = 1'b0;
    next_rst_a = 1'b0;
    next_rst_b = 1'b0;
    if (CHANNEL_MODE_IN == MODE_OFF)
      next_cmp_latch = 1'b0;
    else if (cmp_event)
    begin
      case (CHANNEL_MODE_IN)
        MODE_CMP_HIGH: next_cmp_latch = 1'b1;
        MODE_CMP_LOW: next_cmp_latch = 1'b0;
        MODE_CMP_TOGGLE: next_cmp_latch = !cmp_latch;
        MODE_CMP_SWINT: next_cmp_latch = cmp_latch;
        MODE_CMP_SEVT:
        begin
          // no conversion-start output exists at all
          next_sevt = 1'b1;
          next_rst_a = !TIMER_SEL_IN;
          next_rst_b = TIMER_SEL_IN;
        end
        default: next_cmp_latch = cmp_latch;
      endcase
    end
  end

  // pad drive: compare latch in compare family, port latch otherwise
  always_comb
  begin
    next_pads = '{e_drive: 1'b0, e_oe_n: 1'b1, h_drive: 1'b0, h_oe_n: 1'b1};
    if (use_port_e)
    begin
      next_pads.e_oe_n = PIN_DIR_IN;
      next_pads.e_drive = (family == FAM_COMPARE) ? next_cmp_latch : PORT_LATCH_IN;
    end
    else
    begin
      next_pads.h_oe_n = PIN_DIR_IN;
      next_pads.h_drive = (family == FAM_COMPARE) ? next_cmp_latch : PORT_LATCH_IN;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (SRST_IN)
    begin
      data <= DATA_RST;
      match_q <= 1'b0;
      flag <= 1'b0;
      irq <= 1'b0;
      cmp_latch <= 1'b0;
      sevt <= 1'b0;
      rst_a <= 1'b0;
      rst_b <= 1'b0;
      pads <= '{e_drive: 1'b0, e_oe_n: 1'b1, h_drive: 1'b0, h_oe_n: 1'b1};
    end
    else
    begin
      data <= next_data;
      match_q <= next_match_q;
      flag <= next_flag;
      irq <= next_irq;
      cmp_latch <= next_cmp_latch;
      sevt <= next_sevt;
      rst_a <= next_rst_a;
      rst_b <= next_rst_b;
      pads <= next_pads;
    end
  end

  assign DATA_OUT = data;
  assign IRQ_FLAG_OUT = flag;
  assign IRQ_OUT = irq;
  assign SPECIAL_EVENT_OUT = sevt;
  assign TIMER_A_RESET_OUT = rst_a;
  assign TIMER_B_RESET_OUT = rst_b;
  assign PAD_OUT = pads;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  chk_capture_loads: assert property (
    (cap_strobe && family == FAM_CAPTURE) |=> data == $past(tval))
    else $error("capture did not load the timer value");

  chk_capture_overwrite: assert property (
    (cap_strobe && family == FAM_CAPTURE && flag) |=> flag && data == $past(tval))
    else $error("pending capture was not overwritten");

  chk_flag_sticky: assert property (
    (flag && !IRQ_FLAG_CLR_IN) |=> flag)
    else $error("irq flag cleared without software");

  chk_flag_set_wins: assert property (
    (cap_strobe && family == FAM_CAPTURE && IRQ_FLAG_CLR_IN) |=> flag)
    else $error("clear beat a capture");

  chk_off_latch_low: assert property (
    CHANNEL_MODE_IN == MODE_OFF |=> !cmp_latch)
    else $error("compare latch not low with channel off");

  chk_toggle_match: assert property (
    (cmp_event && CHANNEL_MODE_IN == MODE_CMP_TOGGLE) |=> cmp_latch != $past(cmp_latch) && flag)
    else $error("toggle on match failed");

  chk_swint_pin: assert property (
    (cmp_event && CHANNEL_MODE_IN == MODE_CMP_SWINT) |=> $stable(cmp_latch) && flag)
    else $error("software interrupt mode moved the pin");

  chk_sevt_reset: assert property (
    (cmp_event && CHANNEL_MODE_IN == MODE_CMP_SEVT)
      |=> sevt && (rst_b == $past(TIMER_SEL_IN)) && (rst_a != rst_b))
    else $error("special event did not reset the selected timer");

  chk_pin_map_h: assert property (
    (!use_port_e && !PIN_DIR_IN) |=> !PAD_OUT.h_oe_n && PAD_OUT.e_oe_n)
    else $error("port H pin not driven under map value 0");

  chk_high_match: assert property (
    (cmp_event && CHANNEL_MODE_IN == MODE_CMP_HIGH) |=> cmp_latch && flag)
    else $error("drive-high match did not set the latch");

  chk_low_match: assert property (
    (cmp_event && CHANNEL_MODE_IN == MODE_CMP_LOW) |=> !cmp_latch && flag)
    else $error("drive-low match did not clear the latch");

  chk_event_single: assert property (
    sevt |=> !sevt)
    else $error("special event pulse longer than one cycle");

  chk_event_only_sevt: assert property (
    !(cmp_event && CHANNEL_MODE_IN == MODE_CMP_SEVT) |=> !sevt && !rst_a && !rst_b)
    else $error("trigger pulse without a special event match");

  chk_irq_enabled: assert property (
    IRQ_ENABLE_IN |=> IRQ_OUT == IRQ_FLAG_OUT)
    else $error("enabled interrupt does not follow the flag");

  chk_irq_masked: assert property (
    !IRQ_ENABLE_IN |=> !IRQ_OUT)
    else $error("masked interrupt was raised");

  chk_data_hold: assert property (
    (family != FAM_CAPTURE && !DATA_WR_IN) |=> data == $past(data))
    else $error("data register changed outside capture or write");
endmodule

// ===== ccu_far_side.sv
// far-side model: two timers on the channel clock and the two pad wires
// assumes the bench loads the timers before use and drives the outside pad levels
`timescale 1ns/1ps
module ccu_far_side (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [ccu_pkg::DATA_W-1:0] load_val_in,
  input wire logic a_rst_in,
  input wire logic b_rst_in,
  input wire logic e_lvl_in,
  input wire logic h_lvl_in,
  input wire ccu_pkg::ccu_pads_t pads_in,
  output ccu_pkg::ccu_pad_in_t pad_out,
  output logic [ccu_pkg::DATA_W-1:0] timer_a_out,
  output logic [ccu_pkg::DATA_W-1:0] timer_b_out
);
  import ccu_pkg::*;
  // timers share the channel clock, so a reset pulse lands on the next edge
  always_ff @(posedge clk_in)
  begin
    if (load_in)
      timer_a_out <= load_val_in;
    else if (a_rst_in)
      timer_a_out <= DATA_RST;
    else if (run_in)
      timer_a_out <= timer_a_out + 16'h0001;
    if (load_in)
      timer_b_out <= ~load_val_in;
    else if (b_rst_in)
      timer_b_out <= DATA_RST;
    else if (run_in)
      timer_b_out <= timer_b_out + 16'h0001;
  end
  // a pad the channel drives shows its drive, else the outside level
  assign pad_out.e_level = pads_in.e_oe_n ? e_lvl_in : pads_in.e_drive;
  assign pad_out.h_level = pads_in.h_oe_n ? h_lvl_in : pads_in.h_drive;
endmodule

// ===== capture_compare_unit_test.sv
// self-checking bench for the capture/compare channel
// assumes ccu_pkg, the channel files and ccu_far_side.sv are compiled first
`timescale 1ns/1ps
module capture_compare_unit_test;
  import ccu_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic map = 1'b1;
  logic dir = 1'b1;
  logic e_lvl = 1'b0, h_lvl = 1'b0, port = 1'b0, wr = 1'b0, clr = 1'b0;
  logic ien = 1'b0, tsel = 1'b0, run = 1'b0, load = 1'b0;
  logic [3:0] mode = MODE_OFF;
  logic [15:0] wdata = 16'h0000, lval = 16'h0000, data, ta, tb;
  logic flag, irq, sev, ra, rb, s_sev, s_ra, s_rb;
  ccu_pad_in_t pad_in;
  ccu_pads_t pads;
  int errors = 0;
  int check_count = 0;
  // channel under test and its timers and pads
  ccu_channel ccu_channel_inst (.REF_CLK_IN(clk), .SRST_IN(srst), .PIN_MAP_SELECT_IN(map),
    .PAD_IN(pad_in), .PIN_DIR_IN(dir), .PORT_LATCH_IN(port), .CHANNEL_MODE_IN(mode),
    .DATA_WR_IN(wr), .DATA_WDATA_IN(wdata), .IRQ_FLAG_CLR_IN(clr), .IRQ_ENABLE_IN(ien),
    .TIMER_SEL_IN(tsel), .TIMER_A_IN(ta), .TIMER_B_IN(tb), .DATA_OUT(data),
    .IRQ_FLAG_OUT(flag), .IRQ_OUT(irq), .SPECIAL_EVENT_OUT(sev), .TIMER_A_RESET_OUT(ra),
    .TIMER_B_RESET_OUT(rb), .PAD_OUT(pads));
  ccu_far_side ccu_far_side_inst (.clk_in(clk), .run_in(run), .load_in(load),
    .load_val_in(lval), .a_rst_in(ra), .b_rst_in(rb), .e_lvl_in(e_lvl), .h_lvl_in(h_lvl),
    .pads_in(pads), .pad_out(pad_in), .timer_a_out(ta), .timer_b_out(tb));
  always #2.5 clk = ~clk;
  // compare one value, count it, report a mismatch
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_mode(input logic [3:0] m);
    @(posedge clk);
    mode <= m;
  endtask
  // timer a takes v, timer b its inverse, so a wrong timer select shows
  task automatic load_timer(input logic [15:0] v);
    @(posedge clk);
    lval <= v;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
  endtask
  task automatic clear_flag;
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  // pad change, then room for the synchroniser and the prescaler
  task automatic edge_to(input logic e, input logic h);
    @(posedge clk);
    e_lvl <= e;
    h_lvl <= h;
    step(6);
    @(negedge clk);
  endtask
  task automatic rises(input int n);
    repeat (n)
    begin
      edge_to(1'b1, 1'b1);
      edge_to(1'b0, 1'b0);
    end
  endtask
  task automatic do_reset(input logic m);
    @(posedge clk);
    srst <= 1'b1;
    map <= m;
    step(20);
    srst <= 1'b0;
    @(negedge clk);
    chk("reset data", data, DATA_RST);
    chk("reset flag", flag, 1'b0);
    chk("reset pads", pads, 4'h5);
  endtask
  // timer two below d, data d, then let the timer run into the match
  task automatic match(input logic [3:0] m, input logic [15:0] d, input logic s);
    @(posedge clk);
    tsel <= s;
    lval <= s ? ~(d - 16'h0002) : d - 16'h0002;
    load <= 1'b1;
    @(posedge clk);
    load <= 1'b0;
    wr <= 1'b1;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    mode <= m;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    run <= 1'b1;
    repeat (8)
    begin
      @(negedge clk);
      if (flag === 1'b1)
        break;
    end
    s_sev = sev;
    s_ra = ra;
    s_rb = rb;
    @(posedge clk);
    run <= 1'b0;
    @(negedge clk);
    chk("cmp flag", flag, 1'b1);
  endtask
  task automatic t_capture;
    set_mode(MODE_CAP_RISE);
    dir <= 1'b1;
    ien <= 1'b1;
    load_timer(16'h1234);
    clear_flag;
    edge_to(1'b1, 1'b1);
    chk("rise cap", data, 16'h1234);
    chk("cap flag", flag, 1'b1);
    chk("cap irq", irq, 1'b1);
    load_timer(16'h5678);
    edge_to(1'b0, 1'b0);
    chk("fall ignored", data, 16'h1234);
    set_mode(MODE_CAP_FALL);
    tsel <= 1'b1;
    clear_flag;
    edge_to(1'b1, 1'b1);
    chk("rise ignored", flag, 1'b0);
    edge_to(1'b0, 1'b0);
    chk("fall cap b", data, 16'ha987);
  endtask
  // off between settings clears the count; a direct switch keeps it
  task automatic t_prescale;
    set_mode(MODE_OFF);
    set_mode(MODE_CAP_DIV4);
    tsel <= 1'b0;
    clear_flag;
    load_timer(16'h0a0a);
    rises(3);
    chk("div4 early", flag, 1'b0);
    rises(1);
    chk("div4 cap", data, 16'h0a0a);
    load_timer(16'h0b0b);
    rises(4);
    chk("overwrite", data, 16'h0b0b);
    set_mode(MODE_OFF);
    set_mode(MODE_CAP_DIV16);
    clear_flag;
    load_timer(16'h0c0c);
    rises(15);
    chk("div16 early", flag, 1'b0);
    rises(1);
    chk("div16 cap", data, 16'h0c0c);
    set_mode(MODE_OFF);
    set_mode(MODE_CAP_DIV16);
    rises(2);
    set_mode(MODE_CAP_DIV4);
    clear_flag;
    rises(2);
    chk("count kept", flag, 1'b1);
  endtask
  task automatic t_compare;
    @(posedge clk);
    dir <= 1'b0;
    match(MODE_CMP_HIGH, 16'h0100, 1'b0);
    chk("drive high", {pads.e_oe_n, pads.e_drive}, 2'b01);
    match(MODE_CMP_LOW, 16'h0200, 1'b0);
    chk("drive low", pads.e_drive, 1'b0);
    match(MODE_CMP_TOGGLE, 16'h0300, 1'b0);
    chk("toggle", pads.e_drive, 1'b1);
    match(MODE_CMP_SWINT, 16'h0400, 1'b0);
    chk("swint pin", pads.e_drive, 1'b1);
    chk("swint event", s_sev, 1'b0);
    set_mode(MODE_OFF);
    port <= 1'b1;
    step(3);
    @(negedge clk);
    chk("port latch", pads.e_drive, 1'b1);
    match(MODE_CMP_TOGGLE, 16'h0500, 1'b0);
    chk("latch cleared", pads.e_drive, 1'b1);
    for (int i = 0; i < 2; i++)
    begin
      match(MODE_CMP_SEVT, 16'h0600, i[0]);
      chk("event", s_sev, 1'b1);
      chk("timer reset", {s_ra, s_rb}, {~i[0], i[0]});
      chk("timer zero", i[0] ? tb : ta, 16'h0000);
    end
  endtask
  task automatic t_pin_map;
    do_reset(1'b0);
    set_mode(MODE_CAP_RISE);
    dir <= 1'b1;
    port <= 1'b0;
    tsel <= 1'b0;
    load_timer(16'h0d0d);
    clear_flag;
    edge_to(1'b1, 1'b0);
    chk("e pad ignored", flag, 1'b0);
    edge_to(1'b1, 1'b1);
    chk("h pad cap", data, 16'h0d0d);
    @(posedge clk);
    dir <= 1'b0;
    load_timer(16'h0e0e);
    clear_flag;
    @(posedge clk);
    port <= 1'b1;
    step(4);
    @(negedge clk);
    chk("port write cap", data, 16'h0e0e);
    chk("h pad driven", {pads.h_oe_n, pads.e_oe_n}, 2'b01);
    chk("h pad drive", pads.h_drive, 1'b1);
  endtask
  task automatic stop_test;
    if (errors == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    do_reset(1'b1);
    t_capture;
    t_prescale;
    t_compare;
    t_pin_map;
    stop_test;
  end
  // hang guard: the scenarios need well under 3000 cycles
  initial
  begin
    #15000;
    errors++;
    stop_test;
  end
endmodule
